// *** bst_pkg.sv ***
package bst_pkg;

    // Instruction register.
    localparam int          IR_W          = 4;
    localparam logic [3:0]  IR_EXTEST     = 4'h0;
    localparam logic [3:0]  IR_INTEST     = 4'h1;
    localparam logic [3:0]  IR_SAMPLE     = 4'h2;
    localparam logic [3:0]  IR_IDCODE     = 4'h3;
    localparam logic [3:0]  IR_PULSE_AB   = 4'h9;
    localparam logic [3:0]  IR_PULSE_A    = 4'hA;
    localparam logic [3:0]  IR_PULSE_B    = 4'hB;
    localparam logic [1:0]  IR_BYPASS_TOP = 2'h3;
    localparam logic [3:0]  IR_CAPTURE    = 4'h1;
    localparam logic [3:0]  IR_RESET      = IR_IDCODE;

    // Identification register; all three codes are arbitrary values.
    localparam int          ID_W          = 32;
    localparam logic [3:0]  ID_VERSION    = 4'h1;
    localparam logic [15:0] ID_DEVICE     = 16'hA5C3;
    localparam logic [10:0] ID_MAKER      = 11'h2B5;

    // Boundary chain, cell 0 next to the test data input.
    localparam int          BS_CELLS      = 14;
    localparam int          BS_SCO        = 0;
    localparam int          BS_SCO_EN     = 1;
    localparam int          BS_FCO        = 2;
    localparam int          BS_FCO_EN     = 3;
    localparam int          BS_RST        = 4;
    localparam int          BS_HRS        = 5;
    localparam int          BS_UPS        = 6;
    localparam int          BS_UPS_EN     = 7;
    localparam int          BS_DNS        = 8;
    localparam int          BS_DCK        = 9;
    localparam int          BS_FRS        = 10;
    localparam int          BS_MODE       = 11;
    localparam int          BS_SFS        = 12;
    localparam int          BS_XTAL       = 13;
    localparam logic [13:0] BS_RESET      = 14'h0000;

    // Test pulse timing.
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          PULSE_HZ      = 192_000;
    localparam int          PULSE_HALF    = CLK_HZ / (2 * PULSE_HZ);
    localparam int          PCNT_W        = 5;

    typedef enum logic [3:0] {
        TLR       = 4'h0, RUN_IDLE  = 4'h1, SEL_DR    = 4'h2, CAPTURE_DR = 4'h3,
        SHIFT_DR  = 4'h4, EXIT1_DR  = 4'h5, PAUSE_DR  = 4'h6, EXIT2_DR   = 4'h7,
        UPDATE_DR = 4'h8, SEL_IR    = 4'h9, CAPTURE_IR = 4'hA, SHIFT_IR  = 4'hB,
        EXIT1_IR  = 4'hC, PAUSE_IR  = 4'hD, EXIT2_IR  = 4'hE, UPDATE_IR  = 4'hF
    } bst_tap_e;

    // Pins that the device drives, each with its enable.
    typedef struct packed {
        logic secondClockOutput;
        logic secondClockOutputEn;
        logic firstClockOutput;
        logic firstClockOutputEn;
        logic upstreamData;
        logic upstreamDataEn;
    } bst_out_s;

    // Pins that the device receives.
    typedef struct packed {
        logic resetIn;
        logic halfRateSelect;
        logic downstreamData;
        logic dataClockIn;
        logic frameSync;
        logic modePin;
        logic superframeSync;
        logic crystalInput;
    } bst_in_s;

endpackage : bst_pkg

// *** bst_pulse_gen.sv ***
`timescale 1ns/1ps
module bst_pulse_gen
    import bst_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pulse selection
    input  wire logic enA,
    input  wire logic enB,
    input  wire logic oscRunning,
    // Line interface pair
    output logic      lineOutputA,
    output logic      lineOutputB
);

    logic [PCNT_W-1:0] cnt_ff;
    logic [PCNT_W-1:0] nxt_cnt;
    logic              phase_ff;
    logic              nxt_phase;
    logic              outA_ff;
    logic              nxt_outA;
    logic              outB_ff;
    logic              nxt_outB;

    // Pulses alternate between the two outputs; with no oscillator the line stays idle.
    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_phase = phase_ff;
        if (!oscRunning || !(enA || enB)) begin
            nxt_cnt   = '0;
            nxt_phase = 1'b0;
        end else if (cnt_ff == PCNT_W'(PULSE_HALF - 1)) begin
            nxt_cnt   = '0;
            nxt_phase = ~phase_ff;
        end else begin
            nxt_cnt   = cnt_ff + PCNT_W'(1);
        end
        nxt_outA = oscRunning && enA && phase_ff;
        nxt_outB = oscRunning && enB && !phase_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff   <= '0;
            phase_ff <= 1'b0;
            outA_ff  <= 1'b0;
            outB_ff  <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            phase_ff <= nxt_phase;
            outA_ff  <= nxt_outA;
            outB_ff  <= nxt_outB;
        end
    end

    assign lineOutputA = outA_ff;
    assign lineOutputB = outB_ff;

endmodule : bst_pulse_gen

// *** bst_tap_port.sv ***
`timescale 1ns/1ps
module bst_tap_port
    import bst_pkg::*;
(
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst_n,
    // Test access port
    input  wire logic     tck,
    input  wire logic     tms,
    input  wire logic     tdi,
    output logic          tdo,
    output logic          tdoEn,
    // Pad side
    input  wire bst_in_s  padIn,
    output bst_out_s      padOut,
    // Core side
    input  wire bst_out_s coreOut,
    output bst_in_s       coreIn,
    // Line interface pair
    input  wire logic     oscRunning,
    output logic          lineOutputA,
    output logic          lineOutputB
);

    bst_tap_e              state_ff;
    bst_tap_e              nxt_state;
    logic                  tckPrev_ff;
    logic [IR_W-1:0]       ir_ff;
    logic [IR_W-1:0]       nxt_ir;
    logic [IR_W-1:0]       irSh_ff;
    logic [IR_W-1:0]       nxt_irSh;
    logic [BS_CELLS-1:0]   bsSh_ff;
    logic [BS_CELLS-1:0]   nxt_bsSh;
    logic [BS_CELLS-1:0]   bsUpd_ff;
    logic [BS_CELLS-1:0]   nxt_bsUpd;
    logic [ID_W-1:0]       idSh_ff;
    logic [ID_W-1:0]       nxt_idSh;
    logic                  byp_ff;
    logic                  nxt_byp;
    logic                  tdo_ff;
    logic                  nxt_tdo;
    logic                  tdoEn_ff;
    logic                  nxt_tdoEn;
    logic                  tckRise;
    logic                  tckFall;
    logic                  selBs;
    logic                  selId;
    logic                  drOut;
    logic [BS_CELLS-1:0]   snap;

    function automatic bst_tap_e tapNext(input bst_tap_e s, input logic m);
        case (s)
            TLR:        tapNext = m ? TLR       : RUN_IDLE;
            RUN_IDLE:   tapNext = m ? SEL_DR    : RUN_IDLE;
            SEL_DR:     tapNext = m ? SEL_IR    : CAPTURE_DR;
            CAPTURE_DR: tapNext = m ? EXIT1_DR  : SHIFT_DR;
            SHIFT_DR:   tapNext = m ? EXIT1_DR  : SHIFT_DR;
            EXIT1_DR:   tapNext = m ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR:   tapNext = m ? EXIT2_DR  : PAUSE_DR;
            EXIT2_DR:   tapNext = m ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR:  tapNext = m ? SEL_DR    : RUN_IDLE;
            SEL_IR:     tapNext = m ? TLR       : CAPTURE_IR;
            CAPTURE_IR: tapNext = m ? EXIT1_IR  : SHIFT_IR;
            SHIFT_IR:   tapNext = m ? EXIT1_IR  : SHIFT_IR;
            EXIT1_IR:   tapNext = m ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR:   tapNext = m ? EXIT2_IR  : PAUSE_IR;
            EXIT2_IR:   tapNext = m ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR:  tapNext = m ? SEL_DR    : RUN_IDLE;
            default:    tapNext = TLR;
        endcase
    endfunction : tapNext

    // The test clock is sampled like any other pin, so it must run well below clk.
    assign tckRise = tck && !tckPrev_ff;
    assign tckFall = !tck && tckPrev_ff;

    assign selBs = (ir_ff == IR_EXTEST) || (ir_ff == IR_INTEST) || (ir_ff == IR_SAMPLE);
    assign selId = (ir_ff == IR_IDCODE);
    // Every other code, the 11xx group and the pulse codes included, selects bypass.
    assign drOut = selBs ? bsSh_ff[BS_CELLS-1] : (selId ? idSh_ff[0] : byp_ff);

    // Chain order from TDO, one cell per input and two per output.
    assign snap = {padIn.crystalInput, padIn.superframeSync, padIn.modePin,
                   padIn.frameSync, padIn.dataClockIn, padIn.downstreamData,
                   coreOut.upstreamDataEn, coreOut.upstreamData,
                   padIn.halfRateSelect, padIn.resetIn,
                   coreOut.firstClockOutputEn, coreOut.firstClockOutput,
                   coreOut.secondClockOutputEn, coreOut.secondClockOutput};

    always_comb begin
        nxt_state = state_ff;
        nxt_ir    = ir_ff;
        nxt_irSh  = irSh_ff;
        nxt_bsSh  = bsSh_ff;
        nxt_bsUpd = bsUpd_ff;
        nxt_idSh  = idSh_ff;
        nxt_byp   = byp_ff;
        nxt_tdo   = tdo_ff;
        nxt_tdoEn = tdoEn_ff;
        if (tckRise) begin
            nxt_state = tapNext(state_ff, tms);
            case (state_ff)
                CAPTURE_DR: begin
                    nxt_bsSh = snap;
                    nxt_idSh = {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1};
                    nxt_byp  = 1'b0;
                end
                SHIFT_DR: begin
                    if (selBs) begin
                        nxt_bsSh = {bsSh_ff[BS_CELLS-2:0], tdi};
                    end else if (selId) begin
                        nxt_idSh = {tdi, idSh_ff[ID_W-1:1]};
                    end else begin
                        nxt_byp = tdi;
                    end
                end
                CAPTURE_IR: nxt_irSh = IR_CAPTURE;
                SHIFT_IR:   nxt_irSh = {tdi, irSh_ff[IR_W-1:1]};
                default:    nxt_irSh = irSh_ff;
            endcase
            if (nxt_state == TLR) begin
                nxt_ir = IR_RESET;
            end
        end
        if (tckFall) begin
            if (state_ff == UPDATE_IR) begin
                nxt_ir = irSh_ff;
            end
            if (state_ff == UPDATE_DR && selBs) begin
                nxt_bsUpd = bsSh_ff;
            end
            nxt_tdoEn = (state_ff == SHIFT_DR) || (state_ff == SHIFT_IR);
            nxt_tdo   = (state_ff == SHIFT_IR) ? irSh_ff[0] : drOut;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff   <= TLR;
            tckPrev_ff <= 1'b0;
            ir_ff      <= IR_RESET;
            irSh_ff    <= IR_RESET;
            bsSh_ff    <= BS_RESET;
            bsUpd_ff   <= BS_RESET;
            idSh_ff    <= '0;
            byp_ff     <= 1'b0;
            tdo_ff     <= 1'b0;
            tdoEn_ff   <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            tckPrev_ff <= tck;
            ir_ff      <= nxt_ir;
            irSh_ff    <= nxt_irSh;
            bsSh_ff    <= nxt_bsSh;
            bsUpd_ff   <= nxt_bsUpd;
            idSh_ff    <= nxt_idSh;
            byp_ff     <= nxt_byp;
            tdo_ff     <= nxt_tdo;
            tdoEn_ff   <= nxt_tdoEn;
        end
    end

    assign tdo   = tdo_ff;
    assign tdoEn = tdoEn_ff;

    // Only EXTEST takes the pads and only INTEST the core; SAMPLE stays transparent.
    always_comb begin
        padOut = coreOut;
        coreIn = padIn;
        if (ir_ff == IR_EXTEST) begin
            padOut = {bsUpd_ff[BS_SCO], bsUpd_ff[BS_SCO_EN], bsUpd_ff[BS_FCO],
                      bsUpd_ff[BS_FCO_EN], bsUpd_ff[BS_UPS], bsUpd_ff[BS_UPS_EN]};
        end
        if (ir_ff == IR_INTEST) begin
            coreIn = {bsUpd_ff[BS_RST], bsUpd_ff[BS_HRS], bsUpd_ff[BS_DNS],
                      bsUpd_ff[BS_DCK], bsUpd_ff[BS_FRS], bsUpd_ff[BS_MODE],
                      bsUpd_ff[BS_SFS], bsUpd_ff[BS_XTAL]};
        end
    end

    bst_pulse_gen u_pulse (
        .clk         (clk),
        .rst_n       (rst_n),
        .enA         ((ir_ff == IR_PULSE_AB) || (ir_ff == IR_PULSE_A)),
        .enB         ((ir_ff == IR_PULSE_AB) || (ir_ff == IR_PULSE_B)),
        .oscRunning  (oscRunning),
        .lineOutputA (lineOutputA),
        .lineOutputB (lineOutputB)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence sRiseIn(bst_tap_e s);
        tckRise && state_ff == s;
    endsequence

    sequence sFallIn(bst_tap_e s);
        tckFall && state_ff == s;
    endsequence

    AST_TLR_IDCODE: assert property (state_ff == TLR |-> ir_ff == IR_IDCODE)
        else $error("Instruction not identification in reset state");
    AST_TLR_EXIT: assert property (sRiseIn(TLR) ##0 !tms |=> state_ff == RUN_IDLE)
        else $error("Reset state did not leave on low mode select");
    AST_SHIFT_EXIT: assert property (sRiseIn(SHIFT_DR) ##0 tms |=> state_ff == EXIT1_DR)
        else $error("Shift state did not exit on high mode select");
    AST_BYPASS_DELAY: assert property (sRiseIn(SHIFT_DR) ##0 (!selBs && !selId)
        |=> byp_ff == $past(tdi))
        else $error("Bypass stage did not take the input bit");
    AST_TDO_ENABLE: assert property (tckFall |=>
        tdoEn_ff == ($past(state_ff) == SHIFT_DR || $past(state_ff) == SHIFT_IR))
        else $error("Output enable wrong outside shift states");
    AST_EXTEST_UPDATE: assert property (sFallIn(UPDATE_DR) ##0 ir_ff == IR_EXTEST
        |=> padOut.secondClockOutput == $past(bsSh_ff[BS_SCO]))
        else $error("External test did not update output pin");
    AST_INTEST_DRIVE: assert property (ir_ff == IR_INTEST
        |-> coreIn.crystalInput == bsUpd_ff[BS_XTAL])
        else $error("Internal test not driving core input");
    AST_SAMPLE_TRANSP: assert property (ir_ff == IR_SAMPLE
        |-> padOut == coreOut && coreIn == padIn)
        else $error("Sample disturbed normal operation");
    AST_BYPASS_DECODE: assert property (ir_ff[3:2] == IR_BYPASS_TOP |-> !selBs && !selId)
        else $error("Upper code not decoded as bypass");
    AST_ID_LSB: assert property (sRiseIn(CAPTURE_DR) |=> idSh_ff[0] == 1'b1)
        else $error("Identification LSB not one after capture");
    AST_PULSE_A_ONLY: assert property ((ir_ff == IR_PULSE_A) [*2] |-> !lineOutputB)
        else $error("Output b pulsed under code A");

endmodule : bst_tap_port

// *** bst_tester_model.sv ***
`timescale 1ns/1ps
module bst_tester_model (
    // Clock
    input  wire logic clk,
    // Test access port
    input  wire logic tdo,
    input  wire logic tdoEn,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    // A pull-up holds the test data line while the device leaves it undriven.
    wire tdoLine = tdoEn ? tdo : 1'b1;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // Eight system clocks per test clock, because the sampled port cannot follow 6.25 MHz.
    task automatic tick(input logic m, input logic d, output logic q);
        @(negedge clk);
        tms = m;
        tdi = d;
        q   = tdoLine;
        tck = 1'b1;
        repeat (4) @(negedge clk);
        tck = 1'b0;
        repeat (3) @(negedge clk);
    endtask : tick

    task automatic tap_reset;
        logic q;
        repeat (5) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask : tap_reset

    // Runs one scan from Run-Idle back to Run-Idle, bit 0 first.
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, 1'b0, q);
        if (ir)
            tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask : scan
endmodule : bst_tester_model

// *** bst_tap_port_test.sv ***
`timescale 1ns/1ps
module bst_tap_port_test;
    import bst_pkg::*;
    logic        clk         = 1'b0;
    logic        rst_n       = 1'b0;
    logic        oscRunning  = 1'b0;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        tdo;
    logic        tdoEn;
    logic        lineOutputA;
    logic        lineOutputB;
    bst_in_s     padIn       = '0;
    bst_in_s     coreIn;
    bst_out_s    coreOut     = '0;
    bst_out_s    padOut;
    logic [31:0] rd;
    int          n_errors    = 0;
    int          comparisons = 0;

    always #50 clk = ~clk;

    bst_tap_port dut_u (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdoEn(tdoEn), .padIn(padIn), .padOut(padOut), .coreOut(coreOut),
        .coreIn(coreIn), .oscRunning(oscRunning), .lineOutputA(lineOutputA),
        .lineOutputB(lineOutputB));
    bst_tester_model tester_u (.clk(clk), .tdo(tdo), .tdoEn(tdoEn), .tck(tck), .tms(tms),
        .tdi(tdi));

    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [13:0] snap(input bst_in_s p, input bst_out_s c);
        return {p.crystalInput, p.superframeSync, p.modePin, p.frameSync, p.dataClockIn,
            p.downstreamData, c.upstreamDataEn, c.upstreamData, p.halfRateSelect, p.resetIn,
            c.firstClockOutputEn, c.firstClockOutput, c.secondClockOutputEn,
            c.secondClockOutput};
    endfunction : snap

    function automatic bst_out_s outPins(input logic [13:0] v);
        return {v[BS_SCO], v[BS_SCO_EN], v[BS_FCO], v[BS_FCO_EN], v[BS_UPS], v[BS_UPS_EN]};
    endfunction : outPins

    function automatic bst_in_s inPins(input logic [13:0] v);
        return {v[BS_RST], v[BS_HRS], v[BS_DNS], v[BS_DCK], v[BS_FRS], v[BS_MODE],
            v[BS_SFS], v[BS_XTAL]};
    endfunction : inPins

    function automatic logic [13:0] rev14(input logic [13:0] v);
        logic [13:0] r;
        for (int i = 0; i < 14; i++)
            r[i] = v[13 - i];
        return r;
    endfunction : rev14

    task automatic load_ir(input logic [3:0] code);
        tester_u.scan(1'b1, 4, {28'h0, code}, rd);
        check("ir capture", IR_CAPTURE, rd);
    endtask : load_ir

    // The crystal cell is left out of the comparison: its snapshot is unpredictable.
    task automatic bscan(input logic [13:0] v);
        logic [13:0] cap;
        cap = rev14(snap(padIn, coreOut));
        tester_u.scan(1'b0, 14, {18'h0, rev14(v)}, rd);
        check("capture", cap[13:1], rd[13:1]);
        check("tdo idle", 1'b0, tdoEn);
    endtask : bscan

    task automatic wait_a(input logic lvl, output int k);
        for (k = 0; lineOutputA !== lvl; k++) begin
            if (k == 100) begin
                n_errors++;
                tally_and_finish();
            end
            @(negedge clk);
        end
    endtask : wait_a

    task automatic t_idcode;
        tester_u.scan(1'b0, 32, 32'h0, rd);
        check("idcode", {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1}, rd);
        for (int c = 12; c < 16; c++) begin
            load_ir(4'(c));
            tester_u.scan(1'b0, 8, 32'hB5, rd);
            check("bypass", 32'h6A, rd);
        end
        tester_u.tap_reset();
        tester_u.scan(1'b0, 32, 32'h0, rd);
        check("idcode after reset", {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1}, rd);
    endtask : t_idcode

    task automatic t_boundary;
        padIn   = 8'hA5;
        coreOut = 6'h2D;
        load_ir(IR_SAMPLE);
        bscan(14'h2C9B);
        check("sample pads", coreOut, padOut);
        check("sample core", padIn, coreIn);
        load_ir(IR_EXTEST);
        check("extest preload", outPins(14'h2C9B), padOut);
        padIn = 8'h3C;
        bscan(14'h1536);
        check("extest pads", outPins(14'h1536), padOut);
        check("extest core", padIn, coreIn);
        load_ir(IR_INTEST);
        check("intest core", inPins(14'h1536), coreIn);
        bscan(14'h0ACF);
        check("intest update", inPins(14'h0ACF), coreIn);
        check("intest pads", coreOut, padOut);
    endtask : t_boundary

    task automatic t_pulse;
        logic [3:0] codes [5] = '{4'h9, 4'hA, 4'hB, 4'h8, 4'h2};
        logic [1:0] want  [5] = '{2'b11, 2'b10, 2'b01, 2'b00, 2'b00};
        logic [1:0] seen;
        int         k;
        oscRunning = 1'b1;
        for (int i = 0; i < 5; i++) begin
            load_ir(codes[i]);
            seen = 2'b00;
            repeat (120) begin
                @(negedge clk);
                seen |= {lineOutputA === 1'b1, lineOutputB === 1'b1};
            end
            check("pulse lines", want[i], seen);
        end
        load_ir(IR_PULSE_AB);
        wait_a(1'b0, k);
        wait_a(1'b1, k);
        wait_a(1'b0, k);
        check("pulse half period", PULSE_HALF, k);
        oscRunning = 1'b0;
        repeat (3) @(negedge clk);
        check("pulse stopped", 2'b00, {lineOutputA, lineOutputB});
    endtask : t_pulse

    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        tester_u.tap_reset();
        t_idcode();
        t_boundary();
        t_pulse();
        tally_and_finish();
    end
endmodule : bst_tap_port_test
